/* File: logic/nand_host.v */
// Functional notes
// - Host keeps write strobe high during reads
// - Shared bus carries both directions
// - Host holds spare disable low normally
// - Host tolerates 2013 of 2048 blocks
// - Host only stores the bad-block words; software must skip factory-bad blocks
// - Host writes bytes with select low
`include "nand_ctrl_defines.vh"

module nand_host (
	input wire clk_sys,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg cmdLatch,
	output reg addrLatch,
	output reg chipSelN,
	output reg writeStrobeN,
	output reg read_strobe_n,
	output reg writeGuardN,
	output reg spareOff,
	output reg [7:0] ioOut,
	output reg ioOeN,
	input wire [7:0] ioIn,
	input wire readyBusyIn,
	output reg readyBusyOut,
	output reg readyBusyOeN
);
	// ==========================================================
	// States
	localparam [4:0] S_IDLE = 5'b00001;
	localparam [4:0] S_LOW = 5'b00010;
	localparam [4:0] S_HIGH = 5'b00100;
	localparam [4:0] S_TURN = 5'b01000;
	localparam [4:0] S_WAIT = 5'b10000;

	// Cycle counts kept 32 bits wide, cut to the timer on purpose
	localparam [31:0] LOW_COUNT = `STROBE_LOW_CYC;
	localparam [31:0] HIGH_COUNT = `STROBE_HIGH_CYC;
	localparam [31:0] TURN_COUNT = `TURN_CYC;

	reg [4:0] state_q;
	reg [1:0] op_q;
	reg [7:0] byte_q;
	reg array_q;
	reg [3:0] timer_q;
	reg [31:0] ctrl_q;
	reg [31:0] badLo_q;
	reg [31:0] badHi_q;
	reg refused_q;
	reg [7:0] rdByte_q;
	reg rdValid_q;
	reg busy_q;
	reg [7:0] ioInS1_q;
	reg [7:0] ioInS2_q;

	wire rbSync;
	wire bufInReady;
	wire [7:0] bufData;
	wire bufValid;
	wire bufPop;
	wire bufPush;
	wire apbWrite;
	wire apbRead;
	wire goReq;
	wire [1:0] reqOp;
	wire reqArray;
	wire canStart;
	wire startReq;

	assign apbWrite = psel && penable && pwrite && !pready;
	assign apbRead = psel && penable && !pwrite && !pready;
	assign bufPush = apbWrite && (paddr == `REG_WDATA);
	assign goReq = apbWrite && (paddr == `REG_CTRL) && pwdata[`CTRL_GO_BIT];
	assign reqOp = pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
	assign reqArray = pwdata[`CTRL_ARRAY_BIT];
	// New array operation only once ready is seen high
	assign canStart = (state_q == S_IDLE) && rbSync;
	// Data op only arms GO; the byte comes from the buffer, not CTRL
	assign startReq = goReq && canStart && (reqOp != `OP_WRITE);
	assign bufPop = (state_q == S_IDLE) && bufValid && rbSync
		&& (ctrl_q[`CTRL_OP_MSB:`CTRL_OP_LSB] == `OP_WRITE)
		&& ctrl_q[`CTRL_GO_BIT];

	// ==========================================================
	// Ready/busy synchroniser
	sync_two_ff rbSyncInst (
		.clk_sys(clk_sys),
		.rst(rst),
		.asyncIn(readyBusyIn),
		.syncOut(rbSync)
	);

	// ==========================================================
	// Write data buffer; full buffer refuses further words
	skid_buffer wrBuf (
		.clk_sys(clk_sys),
		.rst(rst),
		.inData(pwdata[7:0]),
		.inValid(bufPush),
		.inReady(bufInReady),
		.outData(bufData),
		.outValid(bufValid),
		.outReady(bufPop)
	);

	// Read bus sampled through two stages, pin is asynchronous
	always @(posedge clk_sys) begin
		if (rst) begin
			ioInS1_q <= 8'h00;
			ioInS2_q <= 8'h00;
		end else begin
			ioInS1_q <= ioIn;
			ioInS2_q <= ioInS1_q;
		end
	end

	// ==========================================================
	// APB slave, one wait state per access
	always @(posedge clk_sys) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			ctrl_q <= `CTRL_RESET;
			badLo_q <= 32'h00000000;
			badHi_q <= 32'h00000000;
			refused_q <= 1'b0;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			if (state_q != S_IDLE) begin
				ctrl_q[`CTRL_GO_BIT] <= 1'b0;
			end
			if (apbWrite) begin
				pready <= 1'b1;
				case (paddr)
				`REG_CTRL: begin
					// Refuse start while busy or while array is busy
					if (pwdata[`CTRL_GO_BIT] && !canStart) begin
						refused_q <= 1'b1;
					end else begin
						ctrl_q <= pwdata;
					end
				end
				`REG_WDATA: begin
					pslverr <= !bufInReady;
				end
				`REG_STATUS: refused_q <= 1'b0;
				// Bad-block map kept by software, host trusts it
				`REG_BADLO: badLo_q <= pwdata;
				`REG_BADHI: badHi_q <= pwdata;
				default: pslverr <= 1'b1;
				endcase
			end else if (apbRead) begin
				pready <= 1'b1;
				case (paddr)
				`REG_CTRL: prdata <= ctrl_q;
				`REG_STATUS: prdata <= {27'h0, refused_q,
					!bufInReady, rdValid_q, rbSync, busy_q};
				`REG_WDATA: prdata <= 32'h00000000;
				`REG_RDATA: prdata <= {24'h000000, rdByte_q};
				`REG_BADLO: prdata <= badLo_q;
				`REG_BADHI: prdata <= badHi_q;
				default: begin
					prdata <= 32'h00000000;
					pslverr <= 1'b1;
				end
				endcase
			end
		end
	end

	// ==========================================================
	// Pin sequencer
	always @(posedge clk_sys) begin
		if (rst) begin
			state_q <= S_IDLE;
			op_q <= `OP_CMD;
			byte_q <= 8'h00;
			array_q <= 1'b0;
			timer_q <= 4'h0;
			busy_q <= 1'b0;
			rdByte_q <= 8'h00;
			rdValid_q <= 1'b0;
			cmdLatch <= 1'b0;
			addrLatch <= 1'b0;
			chipSelN <= 1'b1;
			writeStrobeN <= 1'b1;
			read_strobe_n <= 1'b1;
			writeGuardN <= 1'b0;
			spareOff <= 1'b0;
			ioOut <= 8'h00;
			ioOeN <= 1'b1;
			readyBusyOut <= 1'b0;
			readyBusyOeN <= 1'b1;
		end else begin
			// Guard low keeps device from program/erase
			writeGuardN <= ctrl_q[`CTRL_WGUARD_BIT];
			spareOff <= ctrl_q[`CTRL_SPARE_OFF_BIT];
			// Never driven: line is open drain, pulled up outside
			readyBusyOeN <= 1'b1;
			readyBusyOut <= 1'b0;
			if (apbRead && paddr == `REG_RDATA) begin
				rdValid_q <= 1'b0;
			end
			case (state_q)
			S_IDLE: begin
				busy_q <= 1'b0;
				ioOeN <= 1'b1;
				cmdLatch <= 1'b0;
				addrLatch <= 1'b0;
				if (startReq || bufPop) begin
					busy_q <= 1'b1;
					op_q <= bufPop ? `OP_WRITE : reqOp;
					byte_q <= bufPop ? bufData
						: pwdata[`CTRL_BYTE_MSB:`CTRL_BYTE_LSB];
					array_q <= bufPop ? 1'b0 : reqArray;
					chipSelN <= 1'b0;
					state_q <= S_LOW;
					timer_q <= LOW_COUNT[3:0];
					if (!bufPop && reqOp == `OP_READ) begin
						// Write strobe stays high while device drives
						writeStrobeN <= 1'b1;
						read_strobe_n <= 1'b0;
					end else begin
						cmdLatch <= !bufPop && reqOp == `OP_CMD;
						addrLatch <= !bufPop && reqOp == `OP_ADDR;
						ioOut <= bufPop ? bufData
							: pwdata[`CTRL_BYTE_MSB:`CTRL_BYTE_LSB];
						ioOeN <= 1'b0;
						writeStrobeN <= 1'b0;
					end
				end else begin
					// Keep chip selected; only reset raises chip select again
					chipSelN <= chipSelN;
				end
			end
			S_LOW: begin
				if (timer_q > 4'h1) begin
					timer_q <= timer_q - 4'h1;
				end else begin
					if (op_q == `OP_READ) begin
						rdByte_q <= ioInS2_q;
						rdValid_q <= 1'b1;
					end
					writeStrobeN <= 1'b1;
					read_strobe_n <= 1'b1;
					timer_q <= HIGH_COUNT[3:0];
					state_q <= S_HIGH;
				end
			end
			S_HIGH: begin
				if (timer_q > 4'h1) begin
					timer_q <= timer_q - 4'h1;
				end else begin
					cmdLatch <= 1'b0;
					addrLatch <= 1'b0;
					ioOeN <= 1'b1;
					timer_q <= TURN_COUNT[3:0];
					state_q <= array_q ? S_TURN : S_IDLE;
				end
			end
			S_TURN: begin
				// Allow device to pull ready/busy low first
				if (timer_q > 4'h1) begin
					timer_q <= timer_q - 4'h1;
				end else begin
					state_q <= S_WAIT;
				end
			end
			S_WAIT: begin
				if (rbSync) begin
					state_q <= S_IDLE;
				end
			end
			default: state_q <= S_IDLE;
			endcase
		end
	end
endmodule

/* File: logic/skid_buffer.v */
module skid_buffer (
	input wire clk_sys,
	input wire rst,
	input wire [7:0] inData,
	input wire inValid,
	output wire inReady,
	output wire [7:0] outData,
	output wire outValid,
	input wire outReady
);
	reg [7:0] mem [0:1];
	reg wrPtr_q;
	reg rdPtr_q;
	reg [1:0] count_q;
	wire push;
	wire pop;

	assign inReady = (count_q != 2'd2);
	assign outValid = (count_q != 2'd0);
	assign outData = mem[rdPtr_q];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always @(posedge clk_sys) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			wrPtr_q <= 1'b0;
			rdPtr_q <= 1'b0;
			count_q <= 2'd0;
		end else begin
			if (push) begin
				wrPtr_q <= ~wrPtr_q;
			end
			if (pop) begin
				rdPtr_q <= ~rdPtr_q;
			end
			if (push && !pop) begin
				count_q <= count_q + 2'd1;
			end else if (pop && !push) begin
				count_q <= count_q - 2'd1;
			end
		end
	end
endmodule

/* File: logic/sync_two_ff.v */
module sync_two_ff (
	input wire clk_sys,
	input wire rst,
	input wire asyncIn,
	output wire syncOut
);
	reg stage1_q;
	reg stage2_q;

	// Resets to idle-high, matching a pulled-up line
	always @(posedge clk_sys) begin
		if (rst) begin
			stage1_q <= 1'b1;
			stage2_q <= 1'b1;
		end else begin
			stage1_q <= asyncIn;
			stage2_q <= stage1_q;
		end
	end

	assign syncOut = stage2_q;
endmodule

/* File: shared/nand_ctrl_defines.vh */
`ifndef NAND_CTRL_DEFINES_VH
`define NAND_CTRL_DEFINES_VH

// ==========================================================
// Register offsets (APB byte addresses)
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_WDATA 12'h008
`define REG_RDATA 12'h00C
`define REG_BADLO 12'h010
`define REG_BADHI 12'h014

// ==========================================================
// Command register fields
`define CTRL_GO_BIT 0
`define CTRL_OP_LSB 1
`define CTRL_OP_MSB 2
`define CTRL_SPARE_OFF_BIT 3
`define CTRL_WGUARD_BIT 4
`define CTRL_ARRAY_BIT 5
`define CTRL_BYTE_LSB 8
`define CTRL_BYTE_MSB 15
`define CTRL_RESET 32'h00000000

// Operation codes
`define OP_CMD 2'h0
`define OP_ADDR 2'h1
`define OP_WRITE 2'h2
`define OP_READ 2'h3

// Status fields
`define STAT_BUSY_BIT 0
`define STAT_READY_BIT 1
`define STAT_RVALID_BIT 2
`define STAT_WFULL_BIT 3
`define STAT_REFUSED_BIT 4

// ==========================================================
// Pin timing, ns, and derived cycles at 200 MHz
`define CLK_PERIOD_NS 5
`define T_STROBE_LOW_NS 35
`define T_STROBE_HIGH_NS 25
`define T_TURN_NS 60
`define STROBE_LOW_CYC ((`T_STROBE_LOW_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define STROBE_HIGH_CYC ((`T_STROBE_HIGH_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define TURN_CYC ((`T_TURN_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)

`endif

/* File: test/nand_dev_model.sv */
// ==========================================
// Flash device stand-in, strobe driven
module nand_dev_model (
	input logic cmdLatch,
	input logic addrLatch,
	input logic chipSelN,
	input logic writeStrobeN,
	input logic read_strobe_n,
	input logic writeGuardN,
	input logic [7:0] ioOut,
	input logic ioOeN,
	input logic readyBusyOut,
	input logic readyBusyOeN,
	output logic [7:0] ioIn,
	output logic readyBusyIn
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem[0:255];
	logic [7:0] col = 8'h00;
	logic [7:0] devData = 8'h00;
	logic devOe = 1'b0;
	logic busy = 1'b0;
	always @(posedge writeStrobeN) if (!chipSelN) begin
		if (cmdLatch) begin
			if (ioIn == 8'h10 && writeGuardN) begin
				// Busy runs on whatever chip select does
				busy <= 1'b1;
				busy <= #400 1'b0;
			end
		end else if (addrLatch)
			col = ioIn;
		else begin
			mem[col] = ioIn;
			col++;
		end
	end
	always @(negedge read_strobe_n) if (!chipSelN) begin
		devData = mem[col];
		col++;
		devOe = 1'b1;
	end
	always @(posedge read_strobe_n or posedge chipSelN) devOe <= #15 1'b0;
	// Released bus shows inverted data so a stale sample cannot match
	assign ioIn = !ioOeN ? ioOut : devOe ? devData : ~devData;
	assign readyBusyIn = !busy && (readyBusyOeN || readyBusyOut);
endmodule

/* File: test/nand_host_chk.sv */
// ==========================================
// Pin protocol checks on the host side
module nand_host_chk (
	input logic clk_sys,
	input logic rst,
	input logic cmdLatch,
	input logic addrLatch,
	input logic chipSelN,
	input logic writeStrobeN,
	input logic read_strobe_n,
	input logic ioOeN,
	input logic readyBusyOeN
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_weRd; !read_strobe_n |-> writeStrobeN && ioOeN; endproperty
	a_weRd: assert property (p_weRd) else $error("wr strobe in read");
	property p_csWr; !writeStrobeN |-> !chipSelN && !ioOeN; endproperty
	a_csWr: assert property (p_csWr) else $error("wr unselected");
	property p_wrPulse;
		$fell(writeStrobeN) |-> (!writeStrobeN)[*7] ##1 writeStrobeN;
	endproperty
	a_wrPulse: assert property (p_wrPulse) else $error("wr width");
	property p_rdPulse;
		$fell(read_strobe_n) |-> (!read_strobe_n)[*7] ##1 read_strobe_n;
	endproperty
	a_rdPulse: assert property (p_rdPulse) else $error("rd width");
	property p_latchExcl; !(cmdLatch && addrLatch); endproperty
	a_latchExcl: assert property (p_latchExcl) else $error("both");
	property p_latchHold;
		!writeStrobeN |=> $stable(cmdLatch) && $stable(addrLatch);
	endproperty
	a_latchHold: assert property (p_latchHold) else $error("latch");
	property p_rbNoDrive; readyBusyOeN; endproperty
	a_rbNoDrive: assert property (p_rbNoDrive) else $error("rb");
	property p_rdIdle; !read_strobe_n |-> !cmdLatch && !addrLatch; endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("latch in rd");
endmodule
bind nand_host nand_host_chk u_chk (.clk_sys, .rst, .cmdLatch, .addrLatch,
	.chipSelN, .writeStrobeN, .read_strobe_n, .ioOeN, .readyBusyOeN);

/* File: test/test_nand_host.sv */
`include "nand_ctrl_defines.vh"
module test_nand_host;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdv;
	logic pready, pslverr, cmdLatch, addrLatch, chipSelN, writeStrobeN;
	logic read_strobe_n, writeGuardN, spareOff, ioOeN, readyBusyIn;
	logic readyBusyOut, readyBusyOeN, err, seenLow;
	logic [7:0] ioOut, ioIn;
	int bad_count = 0, num_checks = 0, n;
	// Rows: column, byte written then read back
	logic [15:0] rows[0:3] = '{16'h0155, 16'h02AA, 16'h1000, 16'h11FF};
	initial forever #2.5 clk_sys = ~clk_sys;
	nand_host DUT (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .cmdLatch, .addrLatch, .chipSelN,
		.writeStrobeN, .read_strobe_n, .writeGuardN, .spareOff, .ioOut,
		.ioOeN, .ioIn, .readyBusyIn, .readyBusyOut, .readyBusyOeN);
	nand_dev_model dev (.cmdLatch, .addrLatch, .chipSelN, .writeStrobeN,
		.read_strobe_n, .writeGuardN, .ioOut, .ioOeN, .readyBusyOut,
		.readyBusyOeN, .ioIn, .readyBusyIn);
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chkWord(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task chkFlag(input string nm, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s exp %b got %b", nm, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys) penable <= 1;
		// Only the watchdog ends a wait for pready
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		rdv = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk_sys);
	endtask
	// f is {wait for ready, write guard level}
	task op(input logic [1:0] o, input logic [7:0] b, input logic [1:0] f);
		int k;
		k = 0;
		apb(1, `REG_CTRL, {16'h0000, b, 2'b00, f, 1'b0, o, 1'b1});
		do begin
			apb(0, `REG_STATUS, 0);
			k++;
			if (rdv[`STAT_READY_BIT] === 1'b0) seenLow = 1;
		end while (rdv[`STAT_BUSY_BIT] !== 1'b0 && k < 300);
		if (k >= 300) begin
			bad_count++;
			$display("[FAIL] busy exp 0 got 1");
			finish_test;
		end
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 0;
		@(posedge clk_sys);
		chkFlag("guard", 0, writeGuardN);
		chkFlag("spare", 0, spareOff);
		apb(0, `REG_STATUS, 0);
		chkWord("status", 32'h00000002, rdv);
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			op(0, 8'h80, 1);
			op(1, rows[i][15:8], 1);
			apb(1, `REG_WDATA, {24'h000000, rows[i][7:0]});
			op(2, 0, 1);
			op(0, 8'h10, 3);
			op(1, rows[i][15:8], 1);
			op(3, 0, 1);
			apb(0, `REG_RDATA, 0);
			chkWord("rdata", {24'h000000, rows[i][7:0]}, rdv);
		end
		$display("table test done");
		for (int wg = 1; wg >= 0; wg--) begin
			seenLow = 0;
			op(0, 8'h10, {1'b1, wg[0]});
			chkFlag("rbLow", wg[0], seenLow);
		end
		$display("guard test done");
		op(1, 8'h08, 1);
		n = 0;
		do begin
			apb(1, `REG_WDATA, 32'hA0 + n);
			n++;
		end while (!err && n < 8);
		chkFlag("full", 1, err);
		// Only one byte leaves per GO, so drain one op at a time
		repeat (n - 1) op(2, 0, 1);
		op(1, 8'h08, 1);
		for (int i = 0; i < n - 1; i++) begin
			op(3, 0, 1);
			apb(0, `REG_RDATA, 0);
			chkWord("seq", 32'hA0 + i, rdv);
		end
		$display("buffer test done");
		apb(1, `REG_CTRL, 32'h00001011);
		apb(1, `REG_CTRL, 32'h00001011);
		op(1, 8'h00, 1);
		chkFlag("refused", 1, rdv[`STAT_REFUSED_BIT]);
		apb(1, `REG_CTRL, 32'h00000018);
		chkFlag("spareOn", 1, spareOff);
		apb(1, `REG_BADLO, 32'h00000002);
		apb(0, `REG_BADLO, 0);
		chkWord("badLo", 32'h00000002, rdv);
		apb(1, `REG_BADHI, 32'h80000000);
		apb(0, `REG_BADHI, 0);
		chkWord("badHi", 32'h80000000, rdv);
		apb(1, 12'h020, 0);
		chkFlag("unmapped", 1, err);
		$display("refusal test done");
		finish_test;
	end
	initial begin
		#150us;
		bad_count++;
		finish_test;
	end
endmodule
